// file: verilog/line_transceiver_status_config_regs.sv
// Status and line configuration registers of the sensor-line
// transceiver, with the serial port that reaches them.
// Assumes analog comparators deliver plain digital levels on pins.
//
// Notes on behaviour
// - Inverted level bit is 1 below 8V, 0 above 13V.
// - Inverted level stays live, never interrupts, unaffected by reads.
// - Line driver fault sets fault flag, mode bit and interrupt.
// - Low rail under 2.4V sets its flag and monitor enable.
// - Low rail flag interrupts only when monitoring enabled; read clears.
// - Undervoltage indicator high while flag set and rail still low.
// - Supply under 7.4V sets flag, mode bit, interrupt; always on.
// - Overheat sets mode bit and interrupt flag; status read clears.
// - Overheat flag rearms only after cooling below release level.
// - Aux level 0 below 5.2V with logic out high; 1 above 8V.
// - Line config at address 1, all bits RW, reset to zero.
// - Filter select bit picks 500kHz or 1MHz for both receivers.
// - Fast slew bit speeds both drivers; host sets it for 230kbps.
// - In open drain, sink select 1 is low side, 0 high side.
// - Push-pull select 1 gives push-pull, 0 open drain.
// - Soft driver enable forces driver on, else transmit enable pin.
// - With transmit inputs high, drive level bit sets line level.
// - Receiver disable forces receive output high.
// - Line load bit switches the current sink on and off.
// - A fault other than overheat still present after a status read sets its flag again.
// - Four 8-bit registers selected by a 2-bit address.
`timescale 1ns/10ps
`default_nettype none
module line_transceiver_status_config_regs
    import line_xcvr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sclkPin,
    input  wire logic csPin_n,
    input  wire logic mosiPin,
    output logic      misoOut,
    output logic      misoOeN,
    input  wire logic lineBelowLow,
    input  wire logic lineAboveHigh,
    input  wire logic auxBelowLow,
    input  wire logic auxAboveHigh,
    input  wire logic lineFaultDet,
    input  wire logic lowRailUvDet,
    input  wire logic supplyUvDet,
    input  wire logic overheatWarnDet,
    input  wire logic overheatReleaseDet,
    input  wire logic transmitEnablePin,
    input  wire logic transmitInA,
    input  wire logic transmitInB,
    output logic      irqN,
    output logic      undervoltageIndicator,
    output logic      rxOut,
    output logic      auxInputLogicOut,
    output logic      filterCornerSelect,
    output logic      fastSlewSelect,
    output logic      lineLoadEnable,
    output logic      lineHighSideOn,
    output logic      lineLowSideOn,
    output logic      lineDriverEnabled
);
    import line_xcvr_pkg::*;

    reg_access_if regs ();

    logic [IN_COUNT-1:0] inS;
    reg_byte_t lineConfig_ff;
    reg_byte_t auxConfig_ff;
    logic      lineLevelInverted_ff;
    logic      auxInputLevel_ff;
    logic      lineFaultIrqFlag_ff;
    logic      lineFaultModeFlag_ff;
    logic      lowRailUvFlag_ff;
    logic      lowRailMonitorEnable_ff;
    logic      supplyUvFlag_ff;
    logic      supplyUvModeFlag_ff;
    logic      overheatIrqFlag_ff;
    logic      overheatModeFlag_ff;
    logic      irqN_ff;
    logic      uvInd_ff;
    logic      rxOut_ff;
    logic      auxOut_ff;
    logic      drvHigh_ff;
    logic      drvLow_ff;
    logic      drvOn_ff;
    logic      statusClr;
    logic      driveOn;
    logic      driveData;
    reg_byte_t rdMux;

    // Set-dominant level with hysteresis: hold between thresholds
    function automatic logic hyst(input logic prev,
                                  input logic goOne,
                                  input logic goZero);
        hyst = goOne ? 1'b1 : (goZero ? 1'b0 : prev);
    endfunction

    serial_port_slave u_port (
        .clk     (clk),
        .rst_n   (rst_n),
        .sclkPin (sclkPin),
        .csPin_n (csPin_n),
        .mosiPin (mosiPin),
        .misoOut (misoOut),
        .misoOeN (misoOeN),
        .regs    (regs.port)
    );

    // Comparator and transmit pins are asynchronous to clk
    two_flop_sync #(.WIDTH(IN_COUNT)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({transmitInB, transmitInA, transmitEnablePin,
                 overheatReleaseDet, overheatWarnDet, supplyUvDet,
                 lowRailUvDet, lineFaultDet, auxAboveHigh,
                 auxBelowLow, lineAboveHigh, lineBelowLow}),
        .dout  (inS)
    );

    // A status read clears the sticky flags in the same cycle
    assign statusClr = regs.rdStrobe && (regs.addr == ADDR_STATUS);

    // Live levels follow comparators; reads never touch them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineLevelInverted_ff <= 1'b0;
            auxInputLevel_ff     <= 1'b0;
        end else begin
            lineLevelInverted_ff <= hyst(lineLevelInverted_ff,
                                         inS[IN_LINE_LOW],
                                         inS[IN_LINE_HIGH]);
            auxInputLevel_ff     <= hyst(auxInputLevel_ff,
                                         inS[IN_AUX_HIGH],
                                         inS[IN_AUX_LOW]);
        end
    end

    // Mode bits mirror the fault sources; overheat has hysteresis
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineFaultModeFlag_ff <= 1'b0;
            supplyUvModeFlag_ff  <= 1'b0;
            overheatModeFlag_ff  <= 1'b0;
        end else begin
            lineFaultModeFlag_ff <= inS[IN_LINE_FAULT];
            supplyUvModeFlag_ff  <= inS[IN_SUPPLY_UV];
            overheatModeFlag_ff  <= hyst(overheatModeFlag_ff,
                                         inS[IN_HOT_WARN],
                                         inS[IN_HOT_REL]);
        end
    end

    // Sticky flags: a pending set wins over a clear by status read.
    // Level-set sources reassert right after a read if still present.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineFaultIrqFlag_ff <= 1'b0;
            lowRailUvFlag_ff    <= 1'b0;
            supplyUvFlag_ff     <= 1'b0;
            overheatIrqFlag_ff  <= 1'b0;
        end else begin
            lineFaultIrqFlag_ff <= inS[IN_LINE_FAULT]
                                 | (lineFaultIrqFlag_ff & ~statusClr);
            lowRailUvFlag_ff    <= inS[IN_RAIL_UV]
                                 | (lowRailUvFlag_ff & ~statusClr);
            supplyUvFlag_ff     <= inS[IN_SUPPLY_UV]
                                 | (supplyUvFlag_ff & ~statusClr);
            // Only the rise of the mode bit sets it, so a read while hot
            // keeps it clear until the die has cooled and heated again
            overheatIrqFlag_ff  <= (hyst(overheatModeFlag_ff,
                                         inS[IN_HOT_WARN],
                                         inS[IN_HOT_REL])
                                   & ~overheatModeFlag_ff)
                                 | (overheatIrqFlag_ff & ~statusClr);
        end
    end

    // Monitor enable: set by hardware on low rail, else by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowRailMonitorEnable_ff <= 1'b0;
        end else if (inS[IN_RAIL_UV]) begin
            lowRailMonitorEnable_ff <= 1'b1;
        end else if (regs.wrEn && regs.addr == ADDR_MODE) begin
            lowRailMonitorEnable_ff <= regs.wrData[MD_LOW_RAIL_EN];
        end
    end

    // Configuration writes; status is read-only and ignores writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineConfig_ff <= LINE_CFG_RST;
            auxConfig_ff  <= AUX_CFG_RST;
        end else if (regs.wrEn) begin
            if (regs.addr == ADDR_LINE_CFG) begin
                lineConfig_ff <= regs.wrData;
            end
            if (regs.addr == ADDR_AUX_CFG) begin
                auxConfig_ff <= regs.wrData;
            end
        end
    end

    // Read mux over the four byte registers
    always_comb begin
        rdMux = 8'h00;
        case (regs.addr)
            ADDR_STATUS: begin
                rdMux[ST_AUX_LVL]      = auxInputLevel_ff;
                rdMux[ST_LINE_LVL_INV] = lineLevelInverted_ff;
                rdMux[ST_LINE_FAULT]   = lineFaultIrqFlag_ff;
                rdMux[ST_LOW_RAIL_UV]  = lowRailUvFlag_ff;
                rdMux[ST_SUPPLY_UV]    = supplyUvFlag_ff;
                rdMux[ST_OVERHEAT]     = overheatIrqFlag_ff;
            end
            ADDR_LINE_CFG: rdMux = lineConfig_ff;
            ADDR_AUX_CFG:  rdMux = auxConfig_ff;
            ADDR_MODE: begin
                rdMux[MD_LINE_FAULT]  = lineFaultModeFlag_ff;
                rdMux[MD_SUPPLY_UV]   = supplyUvModeFlag_ff;
                rdMux[MD_OVERHEAT]    = overheatModeFlag_ff;
                rdMux[MD_LOW_RAIL_EN] = lowRailMonitorEnable_ff;
            end
            default: rdMux = 8'h00;
        endcase
    end
    assign regs.rdData = rdMux;

    // Interrupt: level flags drive it low; line level never does
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqN_ff  <= 1'b1;
            uvInd_ff <= 1'b0;
        end else begin
            irqN_ff  <= ~(lineFaultIrqFlag_ff | supplyUvFlag_ff
                        | overheatIrqFlag_ff
                        | (lowRailUvFlag_ff & lowRailMonitorEnable_ff));
            uvInd_ff <= lowRailMonitorEnable_ff & lowRailUvFlag_ff
                      & inS[IN_RAIL_UV];
        end
    end

    // Driver: soft enable or pin; transmit low means line high
    assign driveOn   = lineConfig_ff[CFG_DRV_EN] | inS[IN_TX_EN];
    assign driveData = ~(inS[IN_TX_A] & inS[IN_TX_B])
                     | lineConfig_ff[CFG_LEVEL];

    // Topology picks which switch may conduct
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drvOn_ff   <= 1'b0;
            drvHigh_ff <= 1'b0;
            drvLow_ff  <= 1'b0;
        end else begin
            drvOn_ff   <= driveOn;
            drvHigh_ff <= driveOn & driveData
                        & (lineConfig_ff[CFG_PP] | ~lineConfig_ff[CFG_SINK]);
            drvLow_ff  <= driveOn & ~driveData
                        & (lineConfig_ff[CFG_PP] | lineConfig_ff[CFG_SINK]);
        end
    end

    // Receiver outputs; disable forces the receive output high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxOut_ff  <= 1'b1;
            auxOut_ff <= 1'b1;
        end else begin
            rxOut_ff  <= lineLevelInverted_ff | lineConfig_ff[CFG_RX_DIS];
            auxOut_ff <= ~auxInputLevel_ff;
        end
    end

    // Analog controls come straight from the configuration flops
    assign filterCornerSelect    = lineConfig_ff[CFG_FILTER];
    assign fastSlewSelect        = lineConfig_ff[CFG_SLEW];
    assign lineLoadEnable        = lineConfig_ff[CFG_LOAD];
    assign irqN                  = irqN_ff;
    assign undervoltageIndicator = uvInd_ff;
    assign rxOut                 = rxOut_ff;
    assign auxInputLogicOut      = auxOut_ff;
    assign lineHighSideOn        = drvHigh_ff;
    assign lineLowSideOn         = drvLow_ff;
    assign lineDriverEnabled     = drvOn_ff;

    // Checks on the bank's own behaviour
    line_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        inS[IN_LINE_LOW] |=> lineLevelInverted_ff ##1 rxOut)
        else $error("line level bit not set for low line");

    level_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        statusClr && !inS[IN_LINE_LOW] && !inS[IN_LINE_HIGH]
        |=> $stable(lineLevelInverted_ff))
        else $error("status read changed line level bit");

    line_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
        inS[IN_LINE_FAULT] |=> lineFaultIrqFlag_ff && lineFaultModeFlag_ff
        ##1 !irqN)
        else $error("line fault did not raise flags and interrupt");

    rail_uv_a: assert property (@(posedge clk) disable iff (!rst_n)
        inS[IN_RAIL_UV] |=> lowRailUvFlag_ff && lowRailMonitorEnable_ff)
        else $error("low rail flag or monitor enable not set");

    rail_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        lowRailUvFlag_ff && !lowRailMonitorEnable_ff && !lineFaultIrqFlag_ff
        && !supplyUvFlag_ff && !overheatIrqFlag_ff |=> irqN)
        else $error("disabled low rail flag drove interrupt");

    uv_ind_a: assert property (@(posedge clk) disable iff (!rst_n)
        !inS[IN_RAIL_UV] |=> !undervoltageIndicator)
        else $error("indicator high after rail recovered");

    supply_uv_a: assert property (@(posedge clk) disable iff (!rst_n)
        inS[IN_SUPPLY_UV] |=> supplyUvFlag_ff ##1 !irqN)
        else $error("supply undervoltage did not interrupt");

    hot_rearm_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(overheatIrqFlag_ff) |-> $rose(overheatModeFlag_ff))
        else $error("overheat flag set without new excursion");

    cfg_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        regs.wrEn && regs.addr == ADDR_LINE_CFG
        |=> lineConfig_ff == $past(regs.wrData))
        else $error("line config write not stored");

    soft_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
        lineConfig_ff[CFG_DRV_EN] |=> lineDriverEnabled)
        else $error("soft enable did not turn driver on");

    rx_disable_a: assert property (@(posedge clk) disable iff (!rst_n)
        lineConfig_ff[CFG_RX_DIS] |=> rxOut)
        else $error("receive output low while disabled");

    irq_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        !irqN && statusClr && !inS[IN_LINE_FAULT] && !inS[IN_RAIL_UV]
        && !inS[IN_SUPPLY_UV] && !inS[IN_HOT_WARN] |=> ##1 irqN)
        else $error("interrupt not released after status read");

    aux_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        inS[IN_AUX_HIGH] |=> auxInputLevel_ff ##1 !auxInputLogicOut)
        else $error("aux level or logic out wrong for high input");

    high_side_a: assert property (@(posedge clk) disable iff (!rst_n)
        !lineConfig_ff[CFG_PP] && !lineConfig_ff[CFG_SINK] |=> !lineLowSideOn)
        else $error("low side on in high side open drain");
endmodule
`default_nettype wire

// file: verilog/line_xcvr_pkg.sv
// Package for the line transceiver register bank: addresses, bit
// positions, reset values, serial frame layout and pin sample indices.
// Assumes the serial port uses 16-bit frames, header byte first.
package line_xcvr_pkg;
    typedef logic [1:0] reg_addr_t;
    typedef logic [7:0] reg_byte_t;

    // Register addresses
    localparam reg_addr_t ADDR_STATUS   = 2'h0;
    localparam reg_addr_t ADDR_LINE_CFG = 2'h1;
    localparam reg_addr_t ADDR_AUX_CFG  = 2'h2;
    localparam reg_addr_t ADDR_MODE     = 2'h3;

    // Status bit positions
    localparam int ST_AUX_LVL      = 5;
    localparam int ST_LINE_LVL_INV = 4;
    localparam int ST_LINE_FAULT   = 3;
    localparam int ST_LOW_RAIL_UV  = 2;
    localparam int ST_SUPPLY_UV    = 1;
    localparam int ST_OVERHEAT     = 0;

    // Line configuration bit positions
    localparam int CFG_FILTER = 7;
    localparam int CFG_SLEW   = 6;
    localparam int CFG_SINK   = 5;
    localparam int CFG_PP     = 4;
    localparam int CFG_DRV_EN = 3;
    localparam int CFG_LEVEL  = 2;
    localparam int CFG_RX_DIS = 1;
    localparam int CFG_LOAD   = 0;

    // Mode register bit positions
    localparam int MD_LINE_FAULT  = 4;
    localparam int MD_SUPPLY_UV   = 3;
    localparam int MD_OVERHEAT    = 2;
    localparam int MD_LOW_RAIL_EN = 1;

    // Reset values
    localparam reg_byte_t LINE_CFG_RST = 8'h00;
    localparam reg_byte_t AUX_CFG_RST  = 8'h00;

    // Serial frame layout
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] HEAD_BITS  = 5'h08;
    localparam int HEAD_WRITE = 7;
    localparam int HEAD_ADDR_LSB = 5;

    // Indices of sampled comparator and transmit pins
    localparam int IN_LINE_LOW   = 0;
    localparam int IN_LINE_HIGH  = 1;
    localparam int IN_AUX_LOW    = 2;
    localparam int IN_AUX_HIGH   = 3;
    localparam int IN_LINE_FAULT = 4;
    localparam int IN_RAIL_UV    = 5;
    localparam int IN_SUPPLY_UV  = 6;
    localparam int IN_HOT_WARN   = 7;
    localparam int IN_HOT_REL    = 8;
    localparam int IN_TX_EN      = 9;
    localparam int IN_TX_A       = 10;
    localparam int IN_TX_B       = 11;
    localparam int IN_COUNT      = 12;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_HEAD = 2'b01,
        SPI_DATA = 2'b10,
        SPI_DONE = 2'b11
    } spi_state_t;
endpackage

// file: verilog/reg_access_if.sv
// Interface between the serial port and the register bank.
// Assumes both ends share clk; strobes are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
interface reg_access_if;
    import line_xcvr_pkg::*;
    reg_addr_t addr;
    logic      rdStrobe;
    logic      wrEn;
    reg_byte_t wrData;
    reg_byte_t rdData;
    modport port (output addr, rdStrobe, wrEn, wrData, input rdData);
    modport bank (input addr, rdStrobe, wrEn, wrData, output rdData);
endinterface
`default_nettype wire

// file: verilog/two_flop_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/10ps
`default_nettype none
module two_flop_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
            dout    <= RST_VAL;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// file: verilog/serial_port_slave.sv
// Serial port slave: mode 0, MSB first, 16-bit frames.
// Header: bit7 write, bits6:5 address; then one data byte.
// Assumes sclk is slow against clk (at least 4 clk per half period).
`timescale 1ns/10ps
`default_nettype none
module serial_port_slave
    import line_xcvr_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   sclkPin,
    input  wire logic   csPin_n,
    input  wire logic   mosiPin,
    output logic        misoOut,
    output logic        misoOeN,
    reg_access_if.port  regs
);
    logic [2:0] pinS;
    logic       sclkDly_ff;
    spi_state_t state_ff;
    logic [4:0] bitCnt_ff;
    reg_byte_t  rxShift_ff;
    reg_byte_t  txShift_ff;
    logic       isWrite_ff;
    reg_addr_t  addr_ff;
    logic       rdStrobe_ff;
    logic       wrEn_ff;
    reg_byte_t  wrData_ff;
    logic       misoOeN_ff;
    logic       rise;
    logic       fall;
    reg_byte_t  nxt_rx;

    // Chip select resets to its idle high level
    two_flop_sync #(.WIDTH(3), .RST_VAL(3'h2)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({mosiPin, csPin_n, sclkPin}),
        .dout  (pinS)
    );

    // Edges of the synchronised clock
    assign rise   = pinS[0] & ~sclkDly_ff;
    assign fall   = ~pinS[0] & sclkDly_ff;
    assign nxt_rx = {rxShift_ff[6:0], pinS[2]};

    // Frame sequencer; a rise of chip select aborts any frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkDly_ff  <= 1'b0;
            state_ff    <= SPI_IDLE;
            bitCnt_ff   <= 5'h00;
            rxShift_ff  <= 8'h00;
            isWrite_ff  <= 1'b0;
            addr_ff     <= 2'h0;
            rdStrobe_ff <= 1'b0;
            wrEn_ff     <= 1'b0;
            wrData_ff   <= 8'h00;
        end else begin
            sclkDly_ff  <= pinS[0];
            rdStrobe_ff <= 1'b0;
            wrEn_ff     <= 1'b0;
            if (pinS[1]) begin
                state_ff  <= SPI_IDLE;
                bitCnt_ff <= 5'h00;
            end else begin
                case (state_ff)
                    SPI_IDLE: begin
                        state_ff  <= SPI_HEAD;
                        bitCnt_ff <= 5'h00;
                    end
                    SPI_HEAD: if (rise) begin
                        rxShift_ff <= nxt_rx;
                        bitCnt_ff  <= bitCnt_ff + 5'h01;
                        if (bitCnt_ff == HEAD_BITS - 5'h01) begin
                            isWrite_ff  <= nxt_rx[HEAD_WRITE];
                            addr_ff     <= nxt_rx[HEAD_ADDR_LSB +: 2];
                            rdStrobe_ff <= ~nxt_rx[HEAD_WRITE];
                            state_ff    <= SPI_DATA;
                        end
                    end
                    SPI_DATA: if (rise) begin
                        rxShift_ff <= nxt_rx;
                        bitCnt_ff  <= bitCnt_ff + 5'h01;
                        if (bitCnt_ff == FRAME_BITS - 5'h01) begin
                            wrEn_ff   <= isWrite_ff;
                            wrData_ff <= nxt_rx;
                            state_ff  <= SPI_DONE;
                        end
                    end
                    default: state_ff <= SPI_DONE;
                endcase
            end
        end
    end

    // Read data loads after the header, then shifts on falling edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txShift_ff <= 8'h00;
            misoOeN_ff <= 1'b1;
        end else begin
            misoOeN_ff <= pinS[1];
            if (pinS[1]) begin
                txShift_ff <= 8'h00;
            end else if (rdStrobe_ff) begin
                txShift_ff <= regs.rdData;
            end else if (fall && state_ff == SPI_DATA && bitCnt_ff > HEAD_BITS) begin
                txShift_ff <= {txShift_ff[6:0], 1'b0};
            end
        end
    end

    assign misoOut       = txShift_ff[7];
    assign misoOeN       = misoOeN_ff;
    assign regs.addr     = addr_ff;
    assign regs.rdStrobe = rdStrobe_ff;
    assign regs.wrEn     = wrEn_ff;
    assign regs.wrData   = wrData_ff;
endmodule
`default_nettype wire

// file: dv/host_model.sv
// Host model: serial port master, mode 0, MSB first, 16-bit frames.
// Assumes the 50 ns system clock; half an sclk period is 8 clk.
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic clk,
    input  wire logic misoOut,
    input  wire logic misoOeN,
    output logic      sclkPin,
    output logic      csPin_n,
    output logic      mosiPin
);
    // Idle bus: deselected, serial clock parked low
    initial begin
        sclkPin = 1'b0;
        csPin_n = 1'b1;
        mosiPin = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One frame; read bits are taken at the last eight rises
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        csPin_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosiPin = tx[i];
            wt(8);
            sclkPin = 1'b1;
            if (i < 8 && misoOeN === 1'b0) rx[i] = misoOut;
            wt(8);
            sclkPin = 1'b0;
        end
        csPin_n = 1'b1;
        // Deselected data must not keep the last value
        mosiPin = ~mosiPin;
        wt(8);
    endtask
endmodule
`default_nettype wire

// file: dv/line_transceiver_status_config_regs_tb.sv
// Testbench for the status and line configuration registers.
// Assumes the host model above drives every serial frame.
`timescale 1ns/10ps
`default_nettype none
module line_transceiver_status_config_regs_tb;
    import line_xcvr_pkg::*;
    logic clk, rst_n, sclkPin, csPin_n, mosiPin, misoOut, misoOeN, irqN;
    logic undervoltageIndicator, rxOut, filterCornerSelect, fastSlewSelect;
    logic lineLoadEnable, lineDriverEnabled, auxInputLogicOut, lineHighSideOn, lineLowSideOn;
    logic [11:0] pin;
    reg_byte_t   r, d;
    int          nErrors = 0, samplesChecked = 0;
    line_transceiver_status_config_regs dut (.clk, .rst_n, .sclkPin, .csPin_n,
        .mosiPin, .misoOut, .misoOeN, .lineBelowLow(pin[IN_LINE_LOW]),
        .lineAboveHigh(pin[IN_LINE_HIGH]), .auxBelowLow(pin[IN_AUX_LOW]),
        .auxAboveHigh(pin[IN_AUX_HIGH]), .lineFaultDet(pin[IN_LINE_FAULT]),
        .lowRailUvDet(pin[IN_RAIL_UV]), .supplyUvDet(pin[IN_SUPPLY_UV]),
        .overheatWarnDet(pin[IN_HOT_WARN]), .overheatReleaseDet(pin[IN_HOT_REL]),
        .transmitEnablePin(pin[IN_TX_EN]), .transmitInA(pin[IN_TX_A]),
        .transmitInB(pin[IN_TX_B]), .irqN, .undervoltageIndicator, .rxOut,
        .auxInputLogicOut, .filterCornerSelect, .fastSlewSelect, .lineLoadEnable,
        .lineHighSideOn, .lineLowSideOn, .lineDriverEnabled);
    host_model host (.clk, .misoOut, .misoOeN, .sclkPin, .csPin_n, .mosiPin);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input reg_byte_t got, input reg_byte_t exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Expected switches: push-pull both, open drain one side only
    function automatic logic [1:0] sw(input reg_byte_t c, input logic on, input logic lvl);
        if (!on) return 2'h0;
        if (c[CFG_PP]) return {lvl, ~lvl};
        return c[CFG_SINK] ? {1'b0, ~lvl} : {lvl, 1'b0};
    endfunction
    task automatic rd(input reg_addr_t a);
        host.xfer({1'b0, a, 5'h00, 8'h00}, r);
    endtask
    task automatic wr(input reg_addr_t a, input reg_byte_t v);
        host.xfer({1'b1, a, 5'h00, v}, r);
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", nErrors, samplesChecked);
        if (nErrors == 0 && samplesChecked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog: the whole run needs well under 1 ms
    initial begin
        #3ms;
        nErrors++;
        test_done;
    end
    initial begin
        pin = 12'h106;
        rst_n = 1'b0;
        void'($urandom(11468));
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        host.wt(8);
        chk({7'h00, irqN}, 8'h01);
        rd(ADDR_STATUS);
        rd(ADDR_LINE_CFG);
        chk(r, LINE_CFG_RST);
        // Corner bytes first, then random ones; drive level kept 0
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'hFB : (i == 1) ? 8'h02 : ($urandom & 8'hFB);
            pin[IN_TX_B:IN_TX_EN] = 3'($urandom);
            wr(ADDR_LINE_CFG, d);
            rd(ADDR_LINE_CFG);
            chk(r, d);
            chk({5'h00, filterCornerSelect, fastSlewSelect, lineLoadEnable},
                {5'h00, d[CFG_FILTER], d[CFG_SLEW], d[CFG_LOAD]});
            chk({7'h00, rxOut}, {7'h00, d[CFG_RX_DIS]});
            chk({7'h00, lineDriverEnabled}, {7'h00, d[CFG_DRV_EN] | pin[IN_TX_EN]});
            chk({6'h00, lineHighSideOn, lineLowSideOn}, {6'h00, sw(d, d[CFG_DRV_EN]
                | pin[IN_TX_EN], ~(pin[IN_TX_A] & pin[IN_TX_B]))});
        end
        pin[3:0] = 4'h9;
        host.wt(6);
        rd(ADDR_STATUS);
        chk(r, 8'h30);
        chk({7'h00, auxInputLogicOut}, 8'h00);
        chk({7'h00, irqN}, 8'h01);
        pin[3:0] = 4'h6;
        pin[IN_SUPPLY_UV] = 1'b1;
        host.wt(6);
        pin[IN_SUPPLY_UV] = 1'b0;
        host.wt(6);
        chk({7'h00, irqN}, 8'h00);
        rd(ADDR_STATUS);
        chk(r, 8'h02);
        chk({7'h00, auxInputLogicOut}, 8'h01);
        chk({7'h00, irqN}, 8'h01);
        pin[IN_LINE_FAULT] = 1'b1;
        host.wt(6);
        rd(ADDR_STATUS);
        chk(r, 8'h08);
        chk({7'h00, irqN}, 8'h00);
        pin[IN_LINE_FAULT] = 1'b0;
        host.wt(6);
        rd(ADDR_STATUS);
        chk({7'h00, irqN}, 8'h01);
        pin[IN_RAIL_UV] = 1'b1;
        host.wt(6);
        chk({6'h00, undervoltageIndicator, irqN}, 8'h02);
        pin[IN_RAIL_UV] = 1'b0;
        rd(ADDR_STATUS);
        chk({r[ST_LOW_RAIL_UV], 6'h00, undervoltageIndicator}, 8'h80);
        pin[IN_HOT_REL] = 1'b0;
        pin[IN_HOT_WARN] = 1'b1;
        host.wt(6);
        chk({7'h00, irqN}, 8'h00);
        rd(ADDR_STATUS);
        chk(r, 8'h01);
        pin[IN_HOT_WARN] = 1'b0;
        rd(ADDR_STATUS);
        chk(r, 8'h00);
        chk({7'h00, irqN}, 8'h01);
        rd(ADDR_MODE);
        chk(r, 8'h06);
        pin[IN_HOT_REL] = 1'b1;
        host.wt(6);
        pin[IN_HOT_REL:IN_HOT_WARN] = 2'h1;
        host.wt(6);
        chk({7'h00, irqN}, 8'h00);
        test_done;
    end
endmodule
`default_nettype wire
